// >>> hw/bst_test_port.sv
`timescale 1ns/1ps
`include "bst_consts.svh"

// ************************************************************
// small valid/ready fifo
// ************************************************************
module bst_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = `BST_FIFO_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		wp_d  = push ? AW'((32'(wp_q) + 1) % DEPTH) : wp_q;
		rp_d  = pop ? AW'((32'(rp_q) + 1) % DEPTH) : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end
endmodule

// ************************************************************
// boundary scan test port
// ************************************************************
module bst_test_port import bst_pkg::*; #(
	parameter int          NUM_IO  = `BST_NUM_IO,
	parameter int          NUM_MC  = `BST_NUM_MC,
	// arbitrary identity value, lsb must stay one
	parameter logic [31:0] ID_CODE = 32'h0A5A_5001
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rstn,
	input  wire logic                   bst_en,
	input  wire logic                   prog_en,
	input  wire logic [`BST_TPIN_W-1:0] tpin_i,
	output logic      [`BST_TPIN_W-1:0] tpin_o,
	output logic      [`BST_TPIN_W-1:0] tpin_oe_n,
	input  wire logic [`BST_TPIN_W-1:0] gpio_o,
	input  wire logic [`BST_TPIN_W-1:0] gpio_oe_n,
	output logic      [`BST_TPIN_W-1:0] gpio_i,
	input  wire logic [`BST_NUM_IN-1:0] in_pin_i,
	output logic      [`BST_NUM_IN-1:0] in_core,
	input  wire logic [NUM_IO-1:0]      io_pin_i,
	output logic      [NUM_IO-1:0]      io_pin_o,
	output logic      [NUM_IO-1:0]      io_pin_oe_n,
	input  wire logic [NUM_IO-1:0]      core_io_o,
	input  wire logic [NUM_IO-1:0]      core_io_oe,
	output logic      [NUM_IO-1:0]      io_core,
	input  wire logic [NUM_MC-1:0]      mc_val,
	output logic      [NUM_MC-1:0]      mc_force,
	output logic                        mc_force_en,
	output logic      [`BST_PROG_W-1:0] prog_data,
	output logic                        prog_wr
);
	localparam int IO_BASE = `BST_NUM_IN;
	localparam int MC_BASE = `BST_NUM_IN + `BST_IO_CELL * NUM_IO;
	localparam int BS_LEN  = MC_BASE + NUM_MC;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [`BST_TPIN_W-1:0] tp_s1_q, tp_s2_q;
	logic [`BST_NUM_IN-1:0] in_s1_q, in_s2_q;
	logic [NUM_IO-1:0]      io_s1_q, io_s2_q;
	logic [1:0]             cfg_s1_q, cfg_s2_q;
	logic                   tck_prev_q;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tp_s1_q    <= '0;
			tp_s2_q    <= '0;
			in_s1_q    <= '0;
			in_s2_q    <= '0;
			io_s1_q    <= '0;
			io_s2_q    <= '0;
			cfg_s1_q   <= '0;
			cfg_s2_q   <= '0;
			tck_prev_q <= 1'b0;
		end else begin
			tp_s1_q    <= tpin_i;
			tp_s2_q    <= tp_s1_q;
			in_s1_q    <= in_pin_i;
			in_s2_q    <= in_s1_q;
			io_s1_q    <= io_pin_i;
			io_s2_q    <= io_s1_q;
			cfg_s1_q   <= {prog_en, bst_en};
			cfg_s2_q   <= cfg_s1_q;
			tck_prev_q <= tp_s2_q[`BST_TPIN_TCK];
		end
	end

	logic port_en, prog_ok, tck_rise, tck_fall, tms, tdi;
	assign port_en  = cfg_s2_q[0] | cfg_s2_q[1];
	assign prog_ok  = cfg_s2_q[1];
	assign tck_rise = port_en & tp_s2_q[`BST_TPIN_TCK] & ~tck_prev_q;
	assign tck_fall = port_en & ~tp_s2_q[`BST_TPIN_TCK] & tck_prev_q;
	assign tms      = tp_s2_q[`BST_TPIN_TMS];
	assign tdi      = tp_s2_q[`BST_TPIN_TDI];

	// ************************************************************
	// controller state and scan registers
	// ************************************************************
	bst_state_t              st_q, st_d;
	logic [`BST_IR_W-1:0]    ir_sh_q, ir_sh_d, ir_q, ir_d;
	logic                    byp_q, byp_d;
	logic [`BST_ID_W-1:0]    id_sh_q, id_sh_d;
	logic [`BST_PROG_W-1:0]  pg_sh_q, pg_sh_d, pg_q, pg_d;
	logic                    pg_wr_q, pg_wr_d;
	logic [BS_LEN-1:0]       bs_sh_q, bs_sh_d, bs_cap;
	logic [NUM_IO-1:0]       upd_out_q, upd_out_d, upd_oe_q, upd_oe_d;
	logic [NUM_MC-1:0]       upd_mc_q, upd_mc_d;
	logic                    tdo_q, tdo_d, fifo_push, fifo_ready, fifo_bit;
	logic                    fifo_out, fifo_valid;
	logic                    tdo_en_q, tdo_en_d;

	function automatic bst_state_t next_state(input bst_state_t s, input logic m);
		case (s)
			ST_RESET:    next_state = m ? ST_RESET : ST_IDLE;
			ST_IDLE:     next_state = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR:   next_state = m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR:   next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: next_state = m ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: next_state = m ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: next_state = m ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR:   next_state = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR:   next_state = m ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR:   next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: next_state = m ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: next_state = m ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: next_state = m ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR:   next_state = m ? ST_SEL_DR : ST_IDLE;
			default:     next_state = ST_RESET;
		endcase
	endfunction

	logic is_extest, is_sample, is_prog, is_id, is_bs;
	assign is_extest = (ir_q == `BST_OP_EXTEST);
	assign is_sample = (ir_q == `BST_OP_SAMPLE);
	assign is_id     = (ir_q == `BST_OP_IDCODE);
	assign is_prog   = (ir_q == `BST_OP_PROG) & prog_ok;
	assign is_bs     = is_extest | is_sample;

	always_comb begin
		bs_cap = '0;
		bs_cap[`BST_NUM_IN-1:0] = in_s2_q;
		for (int i = 0; i < NUM_IO; i++) begin
			bs_cap[IO_BASE + `BST_IO_CELL*i + `BST_IO_IN_BIT]  = io_s2_q[i];
			bs_cap[IO_BASE + `BST_IO_CELL*i + `BST_IO_OUT_BIT] = io_pin_o[i];
			bs_cap[IO_BASE + `BST_IO_CELL*i + `BST_IO_OE_BIT]  = ~io_pin_oe_n[i];
		end
		bs_cap[BS_LEN-1:MC_BASE] = mc_val;
	end

	always_comb begin
		st_d      = st_q;
		ir_sh_d   = ir_sh_q;
		ir_d      = ir_q;
		byp_d     = byp_q;
		id_sh_d   = id_sh_q;
		pg_sh_d   = pg_sh_q;
		pg_d      = pg_q;
		pg_wr_d   = 1'b0;
		bs_sh_d   = bs_sh_q;
		upd_out_d = upd_out_q;
		upd_oe_d  = upd_oe_q;
		upd_mc_d  = upd_mc_q;
		fifo_push = 1'b0;
		fifo_bit  = 1'b0;
		// a rise is dropped while the tdo buffer is full
		if (tck_rise && fifo_ready) begin
			st_d = next_state(st_q, tms);
			case (st_q)
				ST_CAP_IR: ir_sh_d = `BST_IR_CAPTURE;
				ST_SHIFT_IR: ir_sh_d = {tdi, ir_sh_q[`BST_IR_W-1:1]};
				ST_CAP_DR: begin
					byp_d   = 1'b0;
					id_sh_d = ID_CODE;
					pg_sh_d = pg_q;
					if (is_bs) begin
						bs_sh_d = bs_cap;
					end
				end
				ST_SHIFT_DR: begin
					if (is_bs) begin
						bs_sh_d = {tdi, bs_sh_q[BS_LEN-1:1]};
					end else if (is_id) begin
						id_sh_d = {tdi, id_sh_q[`BST_ID_W-1:1]};
					end else if (is_prog) begin
						pg_sh_d = {tdi, pg_sh_q[`BST_PROG_W-1:1]};
					end else begin
						byp_d = tdi;
					end
				end
				default: begin
				end
			endcase
			if (st_d == ST_SHIFT_IR) begin
				fifo_push = 1'b1;
				fifo_bit  = ir_sh_d[0];
			end else if (st_d == ST_SHIFT_DR) begin
				fifo_push = 1'b1;
				fifo_bit  = is_bs ? bs_sh_d[0] : is_id ? id_sh_d[0] :
				            is_prog ? pg_sh_d[0] : byp_d;
			end
		end
		if (tck_fall) begin
			if (st_q == ST_UPD_IR) begin
				ir_d = ir_sh_q;
			end
			if (st_q == ST_UPD_DR) begin
				if (is_bs) begin
					for (int i = 0; i < NUM_IO; i++) begin
						upd_out_d[i] = bs_sh_q[IO_BASE + `BST_IO_CELL*i + `BST_IO_OUT_BIT];
						upd_oe_d[i]  = bs_sh_q[IO_BASE + `BST_IO_CELL*i + `BST_IO_OE_BIT];
					end
					upd_mc_d = bs_sh_q[BS_LEN-1:MC_BASE];
				end
				if (is_prog) begin
					pg_d    = pg_sh_q;
					pg_wr_d = 1'b1;
				end
			end
		end
		if (st_q == ST_RESET) begin
			ir_d = `BST_OP_IDCODE;
		end
	end

	// tdo after falling edge
	// driver follows the falling tck too, so the last bit still stands at the next rise
	always_comb begin
		tdo_d    = tdo_q;
		tdo_en_d = tdo_en_q;
		if (tck_fall) begin
			tdo_en_d = (st_q == ST_SHIFT_DR) | (st_q == ST_SHIFT_IR);
			if (fifo_valid) begin
				tdo_d = fifo_out;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q      <= ST_RESET;
			ir_sh_q   <= '0;
			ir_q      <= `BST_OP_IDCODE;
			byp_q     <= 1'b0;
			id_sh_q   <= '0;
			pg_sh_q   <= '0;
			pg_q      <= '0;
			pg_wr_q   <= 1'b0;
			bs_sh_q   <= '0;
			upd_out_q <= '0;
			upd_oe_q  <= '0;
			upd_mc_q  <= '0;
			tdo_q     <= 1'b0;
			tdo_en_q  <= 1'b0;
		end else begin
			st_q      <= st_d;
			ir_sh_q   <= ir_sh_d;
			ir_q      <= ir_d;
			byp_q     <= byp_d;
			id_sh_q   <= id_sh_d;
			pg_sh_q   <= pg_sh_d;
			pg_q      <= pg_d;
			pg_wr_q   <= pg_wr_d;
			bs_sh_q   <= bs_sh_d;
			upd_out_q <= upd_out_d;
			upd_oe_q  <= upd_oe_d;
			upd_mc_q  <= upd_mc_d;
			tdo_q     <= tdo_d;
			tdo_en_q  <= tdo_en_d;
		end
	end

	bst_fifo #(
		.WIDTH (1),
		.DEPTH (`BST_FIFO_DEPTH)
	) u_tdo_fifo (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.in_data   (fifo_bit),
		.in_valid  (fifo_push),
		.in_ready  (fifo_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_valid),
		.out_ready (tck_fall)
	);

	// ************************************************************
	// pin drivers, all registered
	// ************************************************************
	logic ext_on;
	assign ext_on   = is_extest & port_en & (st_q != ST_RESET);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			io_pin_o    <= '0;
			io_pin_oe_n <= '1;
			io_core     <= '0;
			in_core     <= '0;
			mc_force    <= '0;
			mc_force_en <= 1'b0;
			tpin_o      <= '0;
			tpin_oe_n   <= '1;
			gpio_i      <= '0;
			prog_data   <= '0;
			prog_wr     <= 1'b0;
		end else begin
			io_pin_o    <= ext_on ? upd_out_q : core_io_o;
			io_pin_oe_n <= ext_on ? ~upd_oe_q : ~core_io_oe;
			io_core     <= io_s2_q;
			in_core     <= in_s2_q;
			mc_force    <= upd_mc_q;
			mc_force_en <= ext_on;
			gpio_i      <= tp_s2_q;
			prog_data   <= pg_q;
			prog_wr     <= pg_wr_q;
			if (port_en) begin
				tpin_o                 <= '0;
				tpin_oe_n              <= '1;
				tpin_o[`BST_TPIN_TDO]    <= tdo_q;
				tpin_oe_n[`BST_TPIN_TDO] <= ~tdo_en_q;
			end else begin
				tpin_o    <= gpio_o;
				tpin_oe_n <= gpio_oe_n;
			end
		end
	end
endmodule

// >>> hw/bst_consts.svh
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

// ************************************************************
// chain geometry
// ************************************************************
`define BST_NUM_IN      4
`define BST_NUM_IO      96
`define BST_NUM_MC      16
`define BST_IO_CELL     3
`define BST_IO_IN_BIT   0
`define BST_IO_OUT_BIT  1
`define BST_IO_OE_BIT   2

// ************************************************************
// instruction register
// ************************************************************
`define BST_IR_W        4
`define BST_IR_CAPTURE  4'h1
`define BST_OP_EXTEST   4'h0
`define BST_OP_SAMPLE   4'h1
`define BST_OP_IDCODE   4'h2
`define BST_OP_PROG     4'h8
`define BST_OP_BYPASS   4'hF

// ************************************************************
// data registers, shared test pins, tdo buffer
// ************************************************************
`define BST_ID_W        32
`define BST_PROG_W      8
`define BST_TPIN_W      4
`define BST_TPIN_TDI    0
`define BST_TPIN_TMS    1
`define BST_TPIN_TCK    2
`define BST_TPIN_TDO    3
`define BST_FIFO_DEPTH  4

`endif

// >>> hw/bst_pkg.sv
package bst_pkg;
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
		ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
		ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} bst_state_t;
endpackage

// >>> dv/bst_test_port_chk.sv
`timescale 1ns/1ps
// ****
// port checker
// ****
module bst_test_port_chk #(
	parameter int NUM_IO = 96
) (
	input wire logic              sys_clk,
	input wire logic              rstn,
	input wire logic              bst_en,
	input wire logic              prog_en,
	input wire logic [3:0]        tpin_o,
	input wire logic [3:0]        tpin_oe_n,
	input wire logic [3:0]        gpio_o,
	input wire logic [3:0]        gpio_oe_n,
	input wire logic [NUM_IO-1:0] io_pin_i,
	input wire logic [NUM_IO-1:0] io_pin_o,
	input wire logic [NUM_IO-1:0] io_pin_oe_n,
	input wire logic [NUM_IO-1:0] core_io_o,
	input wire logic [NUM_IO-1:0] core_io_oe,
	input wire logic [NUM_IO-1:0] io_core,
	input wire logic              mc_force_en,
	input wire logic              prog_wr
);
	logic       cfg_q;
	logic       cfg_d;
	logic [2:0] age_q;
	logic [2:0] age_d;
	logic       calm;
	// port setting passes a synchroniser, so pins are judged only once it settles
	always_comb begin
		cfg_d = bst_en | prog_en;
		age_d = (cfg_d != cfg_q) ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= 1'b0;
			age_q <= 3'h0;
		end else begin
			cfg_q <= cfg_d;
			age_q <= age_d;
		end
	end
	assign calm = age_q == 3'h7;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	shared_pins_a: assert property (calm && cfg_q |-> tpin_oe_n[2:0] == 3'h7)
		else $error("shared test input pin driven");
	gpio_data_a: assert property (calm && !cfg_q |-> tpin_o == $past(gpio_o))
		else $error("user data not on shared pins");
	gpio_enable_a: assert property (calm && !cfg_q |-> tpin_oe_n == $past(gpio_oe_n))
		else $error("user enable not on shared pins");
	core_drive_a: assert property (calm && !mc_force_en && !$past(mc_force_en)
		|-> io_pin_o == $past(core_io_o))
		else $error("core drive lost outside extest");
	core_enable_a: assert property (calm && !$past(mc_force_en, 2)
		&& !mc_force_en |-> io_pin_oe_n == ~$past(core_io_oe))
		else $error("core enable lost outside extest");
	pin_sample_a: assert property (calm |-> io_core == $past(io_pin_i, 3))
		else $error("pin level not passed to core");
	prog_pulse_a: assert property (prog_wr |=> !prog_wr)
		else $error("program write longer than one cycle");
	prog_gate_a: assert property (prog_wr |-> prog_en)
		else $error("program write without enable");
	force_gate_a: assert property (calm && mc_force_en |-> cfg_q)
		else $error("extest active with port off");
	cover property (prog_wr);
	cover property ($rose(mc_force_en));
	cover property (!tpin_oe_n[3]);
endmodule

bind bst_test_port bst_test_port_chk #(.NUM_IO(NUM_IO)) u_chk (.sys_clk, .rstn, .bst_en,
	.prog_en, .tpin_o, .tpin_oe_n, .gpio_o, .gpio_oe_n, .io_pin_i, .io_pin_o, .io_pin_oe_n,
	.core_io_o, .core_io_oe, .io_core, .mc_force_en, .prog_wr);

// >>> dv/bst_tester.sv
`timescale 1ns/1ps
// ****
// external test controller
// ****
module bst_tester (
	input wire logic       active,
	input wire logic [3:0] tpin_o,
	input wire logic [3:0] tpin_oe_n,
	output logic     [3:0] tpin_i
);
	logic       tck;
	logic       tms;
	logic       tdi;
	logic [3:0] held;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		held = 4'h0;
	end
	// a released line shows the inverse of its last driven level, never a stale copy
	always @(tpin_o or tpin_oe_n) begin
		for (int b = 0; b < 4; b++) begin
			if (!tpin_oe_n[b]) begin
				held[b] = tpin_o[b];
			end
		end
	end
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			tpin_i[b] = tpin_oe_n[b] ? ~held[b] : tpin_o[b];
		end
		if (active) begin
			tpin_i[2:0] = {tck, tms, tdi};
		end
	end
	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#32 tck = 1'b1;
		#28 q = tpin_i[3];
		#4 tck = 1'b0;
	endtask
endmodule

// >>> dv/bst_test_port_tb.sv
`timescale 1ns/1ps
`include "bst_consts.svh"
module bst_test_port_tb;
	// arbitrary identity value
	localparam logic [31:0] ID  = 32'h1357_9BDF;
	localparam int          IO0 = `BST_NUM_IN;
	localparam int          MC0 = IO0 + 3 * `BST_NUM_IO;
	localparam int          N   = MC0 + `BST_NUM_MC;
	logic        sys_clk, rstn, bst_en, prog_en, active, q, e;
	logic [3:0]  tpin_i, tpin_o, tpin_oe_n, gpio_o, gpio_oe_n, gpio_i, in_pin_i, in_core;
	logic [95:0] io_pin_i, io_pin_o, io_pin_oe_n, core_io_o, core_io_oe, io_core;
	logic [15:0] mc_val, mc_force;
	logic        mc_force_en, prog_wr;
	logic [7:0]  prog_data;
	logic [7:0]  wr_q[$];
	logic [3:0]  ops[3];
	logic [511:0] pat, dout;
	logic [31:0] rng;
	int          errors, cmp_count;

	bst_test_port #(.ID_CODE(ID)) DUT (.sys_clk, .rstn, .bst_en, .prog_en, .tpin_i, .tpin_o,
		.tpin_oe_n, .gpio_o, .gpio_oe_n, .gpio_i, .in_pin_i, .in_core, .io_pin_i, .io_pin_o,
		.io_pin_oe_n, .core_io_o, .core_io_oe, .io_core, .mc_val, .mc_force, .mc_force_en,
		.prog_data, .prog_wr);
	bst_tester TST (.active, .tpin_o, .tpin_oe_n, .tpin_i);

	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;
	always @(negedge sys_clk) if (prog_wr === 1'b1) wr_q.push_back(prog_data);

	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task check(input logic [95:0] seen, input logic [95:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		if (errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// link clock phase kept off the system clock edges
	task settle(input int n);
		repeat (n) @(negedge sys_clk);
		#3;
	endtask
	task scan(input logic ir, input int n, input logic [511:0] din);
		TST.tick(1'b1, 1'b0, q);
		if (ir) TST.tick(1'b1, 1'b0, q);
		TST.tick(1'b0, 1'b0, q);
		TST.tick(1'b0, 1'b0, q);
		for (int k = 0; k < n; k++) begin
			TST.tick(k == n - 1, din[k], q);
			dout[k] = q;
		end
		TST.tick(1'b1, 1'b0, q);
		TST.tick(1'b0, 1'b0, q);
	endtask

	initial begin
		rng = 32'h3;
		{errors, cmp_count} = 0;
		{rstn, prog_en, gpio_o, in_pin_i, io_pin_i, core_io_o, core_io_oe, mc_val} = '0;
		{bst_en, active, gpio_oe_n} = 6'h3F;
		ops = '{4'hF, 4'h5, 4'h8};
		repeat (10) @(posedge sys_clk);
		check(96'({tpin_oe_n, prog_wr, mc_force_en}), 96'h3C);
		check(io_pin_oe_n, {96{1'b1}});
		@(negedge sys_clk) rstn = 1'b1;
		settle(4);
		TST.tick(1'b0, 1'b0, q);
		scan(1'b0, 32, '0);
		check(96'(dout[31:0]), 96'(ID));
		foreach (ops[i]) begin
			for (int k = 0; k < 16; k++) pat[32*k +: 32] = rnd();
			scan(1'b1, 4, 512'(ops[i]));
			check(96'(dout[3:0]), 96'h1);
			scan(1'b0, 9, pat);
			check(96'(dout[8:0]), 96'({pat[7:0], 1'b0}));
		end
		@(negedge sys_clk);
		in_pin_i = 4'(rnd());
		io_pin_i = {rnd(), rnd(), rnd()};
		core_io_o = {rnd(), rnd(), rnd()};
		core_io_oe = {rnd(), rnd(), rnd()};
		mc_val = 16'(rnd());
		settle(8);
		scan(1'b1, 4, 512'(4'h1));
		scan(1'b0, N + 1, pat);
		for (int k = 0; k <= N; k++) begin
			if (k < IO0) e = in_pin_i[k];
			else if (k == N) e = pat[0];
			else if (k >= MC0) e = mc_val[k-MC0];
			else if ((k - IO0) % 3 == 0) e = io_pin_i[(k-IO0)/3];
			else if ((k - IO0) % 3 == 1) e = core_io_o[(k-IO0)/3];
			else e = core_io_oe[(k-IO0)/3];
			check(96'(dout[k]), 96'(e));
		end
		scan(1'b1, 4, 512'(4'h0));
		settle(6);
		for (int i = 0; i < 96; i++) begin
			check(96'(io_pin_o[i]), 96'(pat[IO0+3*i+2]));
			check(96'(io_pin_oe_n[i]), 96'(!pat[IO0+3*i+3]));
		end
		for (int m = 0; m < 16; m++) check(96'(mc_force[m]), 96'(pat[MC0+m+1]));
		check(96'({mc_force_en, in_core}), 96'({1'b1, in_pin_i}));
		@(negedge sys_clk) prog_en = 1'b1;
		settle(4);
		scan(1'b1, 4, 512'(4'h8));
		scan(1'b0, 8, 512'(pat[15:8]));
		settle(4);
		check(96'(wr_q.size()), 96'h1);
		if (wr_q.size() > 0) check(96'(wr_q.pop_front()), 96'(pat[15:8]));
		@(negedge sys_clk) {bst_en, prog_en, active} = 3'h0;
		repeat (4) begin
			@(negedge sys_clk) {gpio_o, gpio_oe_n} = 8'(rnd());
			repeat (8) @(negedge sys_clk);
			check(96'({tpin_o, tpin_oe_n, gpio_i}), 96'({gpio_o, gpio_oe_n, tpin_i}));
		end
		// power-up reset in mid-run must bring back the identity instruction
		@(negedge sys_clk) {rstn, bst_en, active} = 3'h3;
		repeat (2) @(negedge sys_clk);
		check(96'({tpin_oe_n, prog_wr}), 96'h1E);
		rstn = 1'b1;
		settle(4);
		TST.tick(1'b0, 1'b0, q);
		scan(1'b0, 32, '0);
		check(96'(dout[31:0]), 96'(ID));
		check(96'(tpin_oe_n), 96'hF);
		report_and_stop();
	end
endmodule
